// >>> core/ffs_cfg.svh
`ifndef FFS_CFG_SVH
`define FFS_CFG_SVH

// Register byte addresses.
`define FFS_OFS_OP_STATUS   8'h00
`define FFS_OFS_ECC_STATUS  8'h04
`define FFS_OFS_CONFIG      8'h08
`define FFS_OFS_ERR_CONFIG  8'h0C

// Operation status field positions.
`define FFS_BIT_DONE        7
`define FFS_BIT_SPARE       6
`define FFS_BIT_ACCESS_ERROR_FLAG      5
`define FFS_BIT_PROT        4
`define FFS_BIT_ACTIVE      3
`define FFS_BIT_RSVD        2
`define FFS_BIT_CSTAT_HI    1
`define FFS_BIT_CSTAT_LO    0

// ECC status field positions.
`define FFS_BIT_DBL         1
`define FFS_BIT_SGL         0

// Configuration field positions.
`define FFS_BIT_DONE_IE     7
`define FFS_BIT_IGN_SGL     4
`define FFS_BIT_FORCE_DBL   1
`define FFS_BIT_FORCE_SGL   0
`define FFS_BIT_SGL_IE      0

// Reset values and data and address widths.
`define FFS_RST_CSTAT       2'h0
`define FFS_RST_BYTE        8'h00
`define FFS_DATA_W          8
`define FFS_ADDR_W          8

`endif

// >>> core/ffs_pkg.sv
package ffs_pkg;

  // Memory controller activity, one-hot.
  typedef enum logic [1:0] {
    FFS_IDLE = 2'b01,
    FFS_RUN  = 2'b10
  } ffs_state_type;

endpackage

// >>> core/ffs_status_flags.sv
// Overview of operation
// - Writing one to done flag launches a command; flag low until completion or violation.
// - Access error flag sets on command sequence violation or illegal command.
// - While access error set, writes of one to done flag are ignored.
// - Writing one clears access error flag; zero leaves it.
// - Protection violation flag sets when protected region program or erase is attempted.
// - Writing one clears protection violation flag; zero leaves it.
// - While protection violation set, no launch and no new sequence start accepted.
// - Active flag reads one while a command executes, zero when idle.
// - Status bit 2 is reserved, reads zero, ignores writes.
// - Completion status field sets on execution or reset sequence errors.
// - Completion status clears when a new command starts.
// - Done, access, protect writable; active, completion read-only; rest read zero.
// - Double fault flag sets on double-bit ECC fault or invalid read.
// - Writing one clears double fault flag; zero leaves it.
// - Single fault flag sets on corrected fault or invalid read unless ignoring.
// - Writing one clears single fault flag; zero leaves it.
// - Fault flags are stored two cycles after the array read.
// - Status may leave reset nonzero when the reset sequence reports errors.
// - Done interrupt request follows done flag when its enable is set.
// - Single fault interrupt request follows its flag when its enable is set.
// - Ignoring single faults suppresses single flag and its interrupt.
// - Forcing double fault makes every array read set the double fault flag.
`timescale 1ns/10ps
`include "ffs_cfg.svh"

module ffs_status_flags
  import ffs_pkg::*;
#(
  parameter int DATA_W = `FFS_DATA_W,
  parameter int ADDR_W = `FFS_ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              cmd_violation,
  input  wire logic              protect_hit,
  input  wire logic              cmd_finish,
  input  wire logic [1:0]        cmd_status,
  input  wire logic              rst_seq_done,
  input  wire logic [1:0]        rst_seq_status,
  input  wire logic              array_read,
  input  wire logic              ecc_single,
  input  wire logic              ecc_double,
  input  wire logic              read_invalid,
  output logic                   cmd_launch,
  output logic                   seq_enable,
  output logic                   done_irq,
  output logic                   single_fault_irq
);

  initial begin
    if (DATA_W != 8 || ADDR_W < 4) begin
      $error("ffs_status_flags needs 8-bit data and at least 4 address bits");
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  ffs_state_type ctl_state;
  logic          access_error_flag;
  logic          protect_violation_flag;
  logic [1:0]    completion_error_status;
  logic          double_fault_flag;
  logic          single_fault_flag;
  logic          done_irq_enable;
  logic          ignore_single_fault;
  logic          force_double_fault;
  logic          force_single_fault;
  logic          single_fault_irq_enable;
  logic          rd_q;
  logic          sgl_q;
  logic          dbl_q;
  logic          inv_q;

  logic wr_stat;
  logic wr_ecc;
  logic command_done_flag;
  logic controller_active_flag;
  logic launch;
  logic end_cmd;
  logic dbl_set;
  logic sgl_set;
  logic next_access_error_flag;
  logic next_protect_violation_flag;
  logic next_double_fault_flag;
  logic next_single_fault_flag;
  logic next_done;

  assign wr_stat                = reg_wr && hit(reg_addr, `FFS_OFS_OP_STATUS);
  assign wr_ecc                 = reg_wr && hit(reg_addr, `FFS_OFS_ECC_STATUS);
  assign controller_active_flag = (ctl_state == FFS_RUN);
  assign command_done_flag      = !controller_active_flag;
  // The launch looks at the flags as they stand, so a write that clears an
  // error and launches at once is refused; software must clear first.
  assign launch = wr_stat && reg_wdata[`FFS_BIT_DONE] && command_done_flag
                  && !access_error_flag && !protect_violation_flag;
  assign end_cmd = controller_active_flag && (cmd_finish || cmd_violation);

  // Command sequencing state.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_state <= FFS_IDLE;
    end else begin
      unique case (ctl_state)
        FFS_IDLE: begin
          if (launch) begin
            ctl_state <= FFS_RUN;
          end
        end
        FFS_RUN: begin
          if (cmd_finish || cmd_violation) begin
            ctl_state <= FFS_IDLE;
          end
        end
        default: begin
          ctl_state <= FFS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_access_error_flag = access_error_flag;
    if (wr_stat && reg_wdata[`FFS_BIT_ACCESS_ERROR_FLAG]) begin
      next_access_error_flag = 1'b0;
    end
    if (cmd_violation) begin
      next_access_error_flag = 1'b1;
    end
  end

  always_comb begin
    next_protect_violation_flag = protect_violation_flag;
    if (wr_stat && reg_wdata[`FFS_BIT_PROT]) begin
      next_protect_violation_flag = 1'b0;
    end
    if (protect_hit) begin
      next_protect_violation_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      access_error_flag      <= 1'b0;
      protect_violation_flag <= 1'b0;
    end else begin
      access_error_flag      <= next_access_error_flag;
      protect_violation_flag <= next_protect_violation_flag;
    end
  end

  // Completion status: cleared at launch, loaded by the engine or the reset
  // sequence; bits accumulate so a reset-time fault is not masked.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      completion_error_status <= `FFS_RST_CSTAT;
    end else if (launch) begin
      completion_error_status <= `FFS_RST_CSTAT;
    end else begin
      if (controller_active_flag && cmd_finish) begin
        completion_error_status <= completion_error_status | cmd_status;
      end else if (rst_seq_done) begin
        completion_error_status <= completion_error_status | rst_seq_status;
      end
    end
  end

  // Array read events are captured first, flags are stored one cycle later.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q  <= 1'b0;
      sgl_q <= 1'b0;
      dbl_q <= 1'b0;
      inv_q <= 1'b0;
    end else begin
      rd_q  <= array_read;
      sgl_q <= array_read && ecc_single;
      dbl_q <= array_read && ecc_double;
      inv_q <= array_read && read_invalid;
    end
  end

  assign dbl_set = rd_q && (dbl_q || inv_q || force_double_fault);
  assign sgl_set = rd_q && !ignore_single_fault
                   && (sgl_q || inv_q || force_single_fault);

  always_comb begin
    next_double_fault_flag = double_fault_flag;
    next_single_fault_flag = single_fault_flag;
    if (wr_ecc && reg_wdata[`FFS_BIT_DBL]) begin
      next_double_fault_flag = 1'b0;
    end
    if (wr_ecc && reg_wdata[`FFS_BIT_SGL]) begin
      next_single_fault_flag = 1'b0;
    end
    if (dbl_set) begin
      next_double_fault_flag = 1'b1;
    end
    if (sgl_set) begin
      next_single_fault_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
    end else begin
      double_fault_flag <= next_double_fault_flag;
      single_fault_flag <= next_single_fault_flag;
    end
  end

  // Configuration registers.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_irq_enable         <= 1'b0;
      ignore_single_fault     <= 1'b0;
      force_double_fault      <= 1'b0;
      force_single_fault      <= 1'b0;
      single_fault_irq_enable <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `FFS_OFS_CONFIG)) begin
        done_irq_enable     <= reg_wdata[`FFS_BIT_DONE_IE];
        ignore_single_fault <= reg_wdata[`FFS_BIT_IGN_SGL];
        force_double_fault  <= reg_wdata[`FFS_BIT_FORCE_DBL];
        force_single_fault  <= reg_wdata[`FFS_BIT_FORCE_SGL];
      end
      if (reg_wr && hit(reg_addr, `FFS_OFS_ERR_CONFIG)) begin
        single_fault_irq_enable <= reg_wdata[`FFS_BIT_SGL_IE];
      end
    end
  end

  // Sequencer handshake and interrupt requests, all from flip-flops.
  assign next_done = !(ctl_state == FFS_IDLE ? launch : !end_cmd);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_launch       <= 1'b0;
      seq_enable       <= 1'b0;
      done_irq         <= 1'b0;
      single_fault_irq <= 1'b0;
    end else begin
      cmd_launch       <= launch;
      seq_enable       <= !next_protect_violation_flag;
      done_irq         <= done_irq_enable && next_done;
      single_fault_irq <= single_fault_irq_enable && next_single_fault_flag;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `FFS_RST_BYTE;
    end else begin
      reg_rdata <= `FFS_RST_BYTE;
      if (reg_rd) begin
        if (hit(reg_addr, `FFS_OFS_OP_STATUS)) begin
          reg_rdata[`FFS_BIT_DONE]                       <= command_done_flag;
          reg_rdata[`FFS_BIT_ACCESS_ERROR_FLAG]                     <= access_error_flag;
          reg_rdata[`FFS_BIT_PROT]                       <= protect_violation_flag;
          reg_rdata[`FFS_BIT_ACTIVE]                     <= controller_active_flag;
          reg_rdata[`FFS_BIT_CSTAT_HI:`FFS_BIT_CSTAT_LO] <= completion_error_status;
        end else if (hit(reg_addr, `FFS_OFS_ECC_STATUS)) begin
          reg_rdata[`FFS_BIT_DBL] <= double_fault_flag;
          reg_rdata[`FFS_BIT_SGL] <= single_fault_flag;
        end else if (hit(reg_addr, `FFS_OFS_CONFIG)) begin
          reg_rdata[`FFS_BIT_DONE_IE]   <= done_irq_enable;
          reg_rdata[`FFS_BIT_IGN_SGL]   <= ignore_single_fault;
          reg_rdata[`FFS_BIT_FORCE_DBL] <= force_double_fault;
          reg_rdata[`FFS_BIT_FORCE_SGL] <= force_single_fault;
        end else if (hit(reg_addr, `FFS_OFS_ERR_CONFIG)) begin
          reg_rdata[`FFS_BIT_SGL_IE] <= single_fault_irq_enable;
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_launch_needs_clean;
    cmd_launch |-> $past(!access_error_flag && !protect_violation_flag);
  endproperty
  a_launch_needs_clean: assert property (p_launch_needs_clean)
    else $error("launch with error flag set");

  property p_launch_blocked_prot;
    protect_violation_flag |=> !cmd_launch;
  endproperty
  a_launch_blocked_prot: assert property (p_launch_blocked_prot)
    else $error("launch during protection violation");

  property p_run_after_launch;
    (reg_wr && hit(reg_addr, `FFS_OFS_OP_STATUS) && reg_wdata[`FFS_BIT_DONE]
     && command_done_flag && !access_error_flag && !protect_violation_flag)
      |=> controller_active_flag && cmd_launch && completion_error_status == `FFS_RST_CSTAT;
  endproperty
  a_run_after_launch: assert property (p_run_after_launch)
    else $error("launch did not start command");

  property p_access_error_flag_set;
    cmd_violation |=> access_error_flag;
  endproperty
  a_access_error_flag_set: assert property (p_access_error_flag_set)
    else $error("access error not set");

  property p_prot_set;
    protect_hit |=> protect_violation_flag && !seq_enable;
  endproperty
  a_prot_set: assert property (p_prot_set)
    else $error("protection flag or gate missing");

  property p_access_error_flag_clear;
    (access_error_flag && reg_wr && hit(reg_addr, `FFS_OFS_OP_STATUS)
     && reg_wdata[`FFS_BIT_ACCESS_ERROR_FLAG] && !cmd_violation) |=> !access_error_flag;
  endproperty
  a_access_error_flag_clear: assert property (p_access_error_flag_clear)
    else $error("access error not cleared");

  property p_dbl_two_cycles;
    (array_read && ecc_double) |=> ##1 double_fault_flag;
  endproperty
  a_dbl_two_cycles: assert property (p_dbl_two_cycles)
    else $error("double fault not stored");

  property p_ignore_sgl;
    (array_read && ignore_single_fault && !single_fault_flag && !force_single_fault)
      ##1 !$changed(ignore_single_fault) |=> !single_fault_flag;
  endproperty
  a_ignore_sgl: assert property (p_ignore_sgl)
    else $error("ignored single fault reported");

  property p_sgl_clear;
    (single_fault_flag && wr_ecc && reg_wdata[`FFS_BIT_SGL] && !sgl_set) |=> !single_fault_flag;
  endproperty
  a_sgl_clear: assert property (p_sgl_clear)
    else $error("single fault not cleared");

  property p_rsvd_zero;
    $past(reg_rd && hit(reg_addr, `FFS_OFS_OP_STATUS))
      |-> !reg_rdata[`FFS_BIT_RSVD] && !reg_rdata[`FFS_BIT_SPARE];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bit nonzero");

  property p_done_irq;
    (done_irq_enable && command_done_flag && !launch) |=> done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("done interrupt missing");

  property p_prot_clear;
    (protect_violation_flag && wr_stat && reg_wdata[`FFS_BIT_PROT] && !protect_hit)
      |=> !protect_violation_flag;
  endproperty
  a_prot_clear: assert property (p_prot_clear)
    else $error("protection flag not cleared");

  property p_dbl_clear;
    (double_fault_flag && wr_ecc && reg_wdata[`FFS_BIT_DBL] && !dbl_set) |=> !double_fault_flag;
  endproperty
  a_dbl_clear: assert property (p_dbl_clear)
    else $error("double fault not cleared");

  property p_force_dbl;
    (array_read && force_double_fault) ##1 force_double_fault |=> double_fault_flag;
  endproperty
  a_force_dbl: assert property (p_force_dbl)
    else $error("forced double fault not stored");

  c_launch_finish: cover property (cmd_launch ##[1:20] (controller_active_flag && cmd_finish));
  c_violation_run: cover property (controller_active_flag && cmd_violation);
  c_set_clear_tie: cover property (sgl_set && wr_ecc && reg_wdata[`FFS_BIT_SGL]);
  c_refused:       cover property (access_error_flag && wr_stat && reg_wdata[`FFS_BIT_DONE]);

endmodule

// >>> verification/ffs_status_flags_tb.sv
`timescale 1ns/10ps
`include "ffs_cfg.svh"
`define TB_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module ffs_status_flags_tb;
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       cmd_violation;
  logic       protect_hit;
  logic       cmd_finish;
  logic [1:0] cmd_status;
  logic       rst_seq_done;
  logic [1:0] rst_seq_status;
  logic       array_read;
  logic       ecc_single;
  logic       ecc_double;
  logic       read_invalid;
  logic       cmd_launch;
  logic       seq_enable;
  logic       done_irq;
  logic       single_fault_irq;
  int         err_count;
  int         total_checks;
  int         cycles;

  ffs_status_flags i_ffs_status_flags (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_violation(cmd_violation), .protect_hit(protect_hit), .cmd_finish(cmd_finish),
    .cmd_status(cmd_status), .rst_seq_done(rst_seq_done), .rst_seq_status(rst_seq_status),
    .array_read(array_read), .ecc_single(ecc_single), .ecc_double(ecc_double),
    .read_invalid(read_invalid), .cmd_launch(cmd_launch), .seq_enable(seq_enable),
    .done_irq(done_irq), .single_fault_irq(single_fault_irq)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    `TB_CHK(nm, e, reg_rdata)
  endtask

  task automatic ev(input int k, input logic [1:0] st);
    @(posedge clock);
    case (k)
      0: cmd_violation <= 1'b1;
      1: protect_hit <= 1'b1;
      2: begin
        cmd_finish <= 1'b1;
        cmd_status <= st;
      end
      default: begin
        rst_seq_done   <= 1'b1;
        rst_seq_status <= st;
      end
    endcase
    @(posedge clock);
    cmd_violation <= 1'b0;
    protect_hit   <= 1'b0;
    cmd_finish    <= 1'b0;
    rst_seq_done  <= 1'b0;
  endtask

  task automatic ar(input logic s, input logic d, input logic inv);
    @(posedge clock);
    array_read   <= 1'b1;
    ecc_single   <= s;
    ecc_double   <= d;
    read_invalid <= inv;
    @(posedge clock);
    array_read   <= 1'b0;
  endtask

  task automatic t_reset();
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "status reset");
    @(posedge clock);
    #1;
    `TB_CHK("rdata after slot", 8'h00, reg_rdata)
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "ecc reset");
    rd_chk(8'h10, 8'h00, "unmapped");
    `TB_CHK("seq_enable reset", 1'b1, seq_enable)
  endtask

  task automatic t_launch();
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    #1;
    `TB_CHK("launch", 1'b1, cmd_launch)
    rd_chk(`FFS_OFS_OP_STATUS, 8'h08, "running");
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    #1;
    `TB_CHK("relaunch while running", 1'b0, cmd_launch)
    ev(2, 2'b10);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h82, "completion error");
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h08, "completion cleared");
    ev(0, 2'b00);
    rd_chk(`FFS_OFS_OP_STATUS, 8'hA0, "violation ends run");
  endtask

  task automatic t_access_error_flag();
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    #1;
    `TB_CHK("launch blocked by error", 1'b0, cmd_launch)
    wr(`FFS_OFS_OP_STATUS, 8'h00);
    rd_chk(`FFS_OFS_OP_STATUS, 8'hA0, "zero keeps error");
    @(posedge clock);
    reg_addr      <= `FFS_OFS_OP_STATUS;
    reg_wdata     <= 8'h20;
    reg_wr        <= 1'b1;
    cmd_violation <= 1'b1;
    @(posedge clock);
    reg_wr        <= 1'b0;
    cmd_violation <= 1'b0;
    rd_chk(`FFS_OFS_OP_STATUS, 8'hA0, "set beats clear");
    wr(`FFS_OFS_OP_STATUS, 8'h20);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "error cleared");
    ev(3, 2'b01);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h81, "reset sequence error");
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    ev(2, 2'b00);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "clean completion");
  endtask

  task automatic t_protect();
    ev(1, 2'b00);
    @(posedge clock);
    #1;
    `TB_CHK("sequence start blocked", 1'b0, seq_enable)
    rd_chk(`FFS_OFS_OP_STATUS, 8'h90, "protect set");
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    #1;
    `TB_CHK("launch blocked by protect", 1'b0, cmd_launch)
    wr(`FFS_OFS_OP_STATUS, 8'h00);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h90, "zero keeps protect");
    wr(`FFS_OFS_OP_STATUS, 8'h10);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "protect cleared");
    `TB_CHK("sequence start allowed", 1'b1, seq_enable)
    wr(`FFS_OFS_OP_STATUS, 8'h4F);
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "read-only bits");
  endtask

  task automatic t_ecc();
    ar(1'b0, 1'b1, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h02, "double fault");
    wr(`FFS_OFS_ECC_STATUS, 8'h00);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h02, "zero keeps double");
    wr(`FFS_OFS_ECC_STATUS, 8'h02);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "double cleared");
    wr(`FFS_OFS_ERR_CONFIG, 8'h01);
    ar(1'b1, 1'b0, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h01, "single fault");
    `TB_CHK("single irq", 1'b1, single_fault_irq)
    wr(`FFS_OFS_ECC_STATUS, 8'h01);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "single cleared");
    `TB_CHK("single irq off", 1'b0, single_fault_irq)
    wr(`FFS_OFS_CONFIG, 8'h10);
    ar(1'b1, 1'b0, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "single ignored");
    `TB_CHK("ignored irq", 1'b0, single_fault_irq)
    wr(`FFS_OFS_CONFIG, 8'h02);
    ar(1'b0, 1'b0, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h02, "forced double");
    wr(`FFS_OFS_CONFIG, 8'h00);
    wr(`FFS_OFS_ECC_STATUS, 8'h03);
    ar(1'b0, 1'b0, 1'b1);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h03, "invalid read");
    wr(`FFS_OFS_ECC_STATUS, 8'h03);
    wr(`FFS_OFS_CONFIG, 8'h01);
    ar(1'b0, 1'b0, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h01, "forced single");
    wr(`FFS_OFS_ECC_STATUS, 8'h01);
    wr(`FFS_OFS_CONFIG, 8'h11);
    ar(1'b0, 1'b0, 1'b0);
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "forced single ignored");
  endtask

  // Reset while idle, with flags and enables set, must bring everything back to the reset state.
  task automatic t_midreset();
    ev(0, 2'b00);
    ar(1'b0, 1'b1, 1'b0);
    wr(`FFS_OFS_CONFIG, 8'h80);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    #1;
    `TB_CHK("seq_enable in reset", 1'b0, seq_enable)
    `TB_CHK("done irq in reset", 1'b0, done_irq)
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    `TB_CHK("seq_enable after reset", 1'b1, seq_enable)
    rd_chk(`FFS_OFS_OP_STATUS, 8'h80, "status after reset");
    rd_chk(`FFS_OFS_ECC_STATUS, 8'h00, "ecc after reset");
    rd_chk(`FFS_OFS_CONFIG, 8'h00, "config after reset");
  endtask

  task automatic t_irq();
    wr(`FFS_OFS_CONFIG, 8'h80);
    repeat (2) @(posedge clock);
    #1;
    `TB_CHK("done irq idle", 1'b1, done_irq)
    wr(`FFS_OFS_OP_STATUS, 8'h80);
    repeat (2) @(posedge clock);
    #1;
    `TB_CHK("done irq running", 1'b0, done_irq)
    ev(2, 2'b00);
    repeat (2) @(posedge clock);
    #1;
    `TB_CHK("done irq complete", 1'b1, done_irq)
    wr(`FFS_OFS_CONFIG, 8'h00);
  endtask

  initial begin
    sys_rst        = 1'b1;
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    cmd_violation  = 1'b0;
    protect_hit    = 1'b0;
    cmd_finish     = 1'b0;
    cmd_status     = 2'h0;
    rst_seq_done   = 1'b0;
    rst_seq_status = 2'h0;
    array_read     = 1'b0;
    ecc_single     = 1'b0;
    ecc_double     = 1'b0;
    read_invalid   = 1'b0;
    err_count      = 0;
    total_checks   = 0;
    cycles         = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_launch();
    t_access_error_flag();
    t_protect();
    t_ecc();
    t_midreset();
    t_irq();
    end_sim();
  end
endmodule
